/* File: logic/eep_core.sv */
// Two-wire serial EEPROM slave with page write, program cycle and APB status
module eep_core #(
	parameter int ADDR_W      = eep_pkg::ADDR_W_DEF,
	parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       resetn,
	input  wire logic                       scl,
	input  wire logic                       sda_i,
	output      logic                       sda_o,
	output      logic                       sda_oe,
	input  wire logic                       write_protect,
	input  wire logic                       device_select_pin_0,
	input  wire logic                       device_select_pin_1,
	input  wire logic                       device_select_pin_2,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [eep_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output      logic [31:0]                prdata,
	output      logic                       pready,
	output      logic                       pslverr
);
	localparam int MEM_DEPTH = 1 << ADDR_W;
	localparam int CNT_W     = $clog2(PROG_CYCLES + 1);
	localparam int ARR_SEL   = ADDR_W - eep_pkg::ARRAY_SEL_BASE;

	typedef struct packed {
		eep_pkg::eep_state_t                      st;
		eep_pkg::eep_state_t                      after_ack;
		logic                                     scl_d;
		logic                                     sda_d;
		logic [3:0]                               bitcnt;
		logic [7:0]                               shreg;
		logic [ADDR_W-1:0]                        ptr;
		logic [eep_pkg::PAGE_BYTES-1:0][7:0]      pbuf;
		logic [eep_pkg::PAGE_BYTES-1:0]           pmask;
		logic                                     first;
		logic                                     wp_lat;
		logic                                     mack;
		logic                                     busy;
		logic [CNT_W-1:0]                         timer;
		logic                                     drive_low;
		logic                                     enable;
		logic [31:0]                              rdata;
	} eep_core_t;

	eep_core_t              q;
	eep_core_t              n;
	logic [5:0]             pins_s;
	logic                   s_scl;
	logic                   s_sda;
	logic                   s_wp;
	logic [2:0]             s_sel;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_cond;
	logic                   stop_cond;
	logic                   sel_ok;
	logic                   prog_done;
	logic [7:0]             rd_byte;
	logic [7:0]             mem [MEM_DEPTH];

	function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p);
		ptr_next = p + ADDR_W'(1);
	endfunction

	function automatic logic reg_hit(input logic [eep_pkg::APB_AW-1:0] a);
		reg_hit = (a == eep_pkg::REG_CTRL) || (a == eep_pkg::REG_STATUS) ||
			(a == eep_pkg::REG_ADDR);
	endfunction

	eep_sync #(
		.WIDTH(6)
	) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in ({device_select_pin_2, device_select_pin_1, device_select_pin_0,
			write_protect, sda_i, scl}),
		.sync_out (pins_s)
	);

	assign s_scl      = pins_s[0];
	assign s_sda      = pins_s[1];
	assign s_wp       = pins_s[2];
	assign s_sel      = pins_s[5:3];
	assign scl_rise   = s_scl & ~q.scl_d;
	assign scl_fall   = ~s_scl & q.scl_d;
	assign start_cond = q.scl_d & s_scl & q.sda_d & ~s_sda;
	assign stop_cond  = q.scl_d & s_scl & ~q.sda_d & s_sda;
	assign prog_done  = q.busy && (q.timer == '0);
	assign rd_byte    = mem[q.ptr];

	// Select bits below the array width carry address, the rest must match pins
	always_comb begin
		sel_ok = 1'b1;
		for (int i = 0; i < eep_pkg::SEL_BITS; i++) begin
			if (i >= ARR_SEL && q.shreg[1+i] != s_sel[i]) begin
				sel_ok = 1'b0;
			end
		end
	end

	always_comb begin
		n       = q;
		n.scl_d = s_scl;
		n.sda_d = s_sda;

		// Internal program cycle
		if (q.busy) begin
			if (q.timer == '0) begin
				n.busy  = 1'b0;
				n.pmask = '0;
			end else begin
				n.timer = q.timer - CNT_W'(1);
			end
		end

		if (start_cond) begin
			n.st        = eep_pkg::EEP_DEV;
			n.bitcnt    = '0;
			n.drive_low = 1'b0;
			// Repeated START before STOP drops any unprogrammed page data
			if (!q.busy) begin
				n.pmask = '0;
			end
		end else if (stop_cond) begin
			n.st        = eep_pkg::EEP_IDLE;
			n.drive_low = 1'b0;
			if (!q.busy && q.pmask != '0) begin
				n.busy  = 1'b1;
				n.timer = CNT_W'(PROG_CYCLES - 1);
			end
		end else begin
			case (q.st)
				eep_pkg::EEP_DEV, eep_pkg::EEP_WORD, eep_pkg::EEP_DATA: begin
					if (scl_rise && q.bitcnt != eep_pkg::BITS_PER_BYTE) begin
						n.shreg  = {q.shreg[6:0], s_sda};
						n.bitcnt = q.bitcnt + 4'h1;
					end else if (scl_fall && q.bitcnt == eep_pkg::BITS_PER_BYTE) begin
						n.bitcnt    = '0;
						n.st        = eep_pkg::EEP_ACK;
						n.drive_low = 1'b1;
						if (q.st == eep_pkg::EEP_DEV) begin
							if (q.shreg[7:4] == eep_pkg::DEV_CODE && sel_ok && !q.busy &&
								q.enable) begin
								for (int i = 0; i < eep_pkg::SEL_BITS; i++) begin
									if (i < ARR_SEL) begin
										n.ptr[eep_pkg::ARRAY_SEL_BASE+i] = q.shreg[1+i];
									end
								end
								if (q.shreg[0]) begin
									n.after_ack = eep_pkg::EEP_TX;
								end else begin
									n.after_ack = eep_pkg::EEP_WORD;
								end
							end else begin
								n.st        = eep_pkg::EEP_IDLE;
								n.drive_low = 1'b0;
							end
						end else if (q.st == eep_pkg::EEP_WORD) begin
							n.ptr[7:0]  = q.shreg;
							n.after_ack = eep_pkg::EEP_DATA;
							n.pmask     = '0;
							n.first     = 1'b1;
						end else if (q.wp_lat) begin
							n.st        = eep_pkg::EEP_IDLE;
							n.drive_low = 1'b0;
							n.pmask     = '0;
						end else begin
							n.pbuf[q.ptr[eep_pkg::PAGE_W-1:0]]  = q.shreg;
							n.pmask[q.ptr[eep_pkg::PAGE_W-1:0]] = 1'b1;
							n.ptr[eep_pkg::PAGE_W-1:0] =
								q.ptr[eep_pkg::PAGE_W-1:0] + 4'h1;
							n.after_ack = eep_pkg::EEP_DATA;
						end
					end
				end
				eep_pkg::EEP_ACK: begin
					if (scl_fall) begin
						n.drive_low = 1'b0;
						n.st        = q.after_ack;
						n.bitcnt    = '0;
						if (q.after_ack == eep_pkg::EEP_DATA && q.first) begin
							n.wp_lat = s_wp;
							n.first  = 1'b0;
						end
						if (q.after_ack == eep_pkg::EEP_TX) begin
							n.shreg     = rd_byte;
							n.ptr       = ptr_next(q.ptr);
							n.drive_low = ~rd_byte[7];
						end
					end
				end
				eep_pkg::EEP_TX: begin
					if (scl_fall) begin
						if (q.bitcnt == eep_pkg::LAST_TX_BIT) begin
							n.drive_low = 1'b0;
							n.st        = eep_pkg::EEP_TXACK;
						end else begin
							n.shreg     = {q.shreg[6:0], 1'b0};
							n.bitcnt    = q.bitcnt + 4'h1;
							n.drive_low = ~q.shreg[6];
						end
					end
				end
				eep_pkg::EEP_TXACK: begin
					if (scl_rise) begin
						n.mack = ~s_sda;
					end else if (scl_fall) begin
						if (q.mack) begin
							n.st        = eep_pkg::EEP_TX;
							n.bitcnt    = '0;
							n.shreg     = rd_byte;
							n.ptr       = ptr_next(q.ptr);
							n.drive_low = ~rd_byte[7];
						end else begin
							n.st = eep_pkg::EEP_IDLE;
						end
					end
				end
				eep_pkg::EEP_IDLE: begin
					n.drive_low = 1'b0;
				end
				default: begin
					n.st        = eep_pkg::EEP_IDLE;
					n.drive_low = 1'b0;
				end
			endcase
		end

		// APB: read data is captured in the setup cycle, so access needs no wait
		if (psel && !penable) begin
			n.rdata = '0;
			case (paddr)
				eep_pkg::REG_CTRL: begin
					n.rdata[eep_pkg::CTRL_EN_BIT] = q.enable;
				end
				eep_pkg::REG_STATUS: begin
					n.rdata[eep_pkg::STAT_BUSY_BIT] = q.busy;
					n.rdata[eep_pkg::STAT_WP_BIT]   = q.wp_lat;
					n.rdata[eep_pkg::STAT_ST_MSB:eep_pkg::STAT_ST_LSB] = q.st;
				end
				eep_pkg::REG_ADDR: begin
					n.rdata[ADDR_W-1:0] = q.ptr;
				end
				default: begin
					n.rdata = '0;
				end
			endcase
		end
		if (psel && penable && pwrite && paddr == eep_pkg::REG_CTRL) begin
			n.enable = pwdata[eep_pkg::CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q        <= '0;
			q.scl_d  <= 1'b1;
			q.sda_d  <= 1'b1;
			q.enable <= eep_pkg::CTRL_EN_RST;
		end else begin
			q <= n;
		end
	end

	// Array: erased at reset, page buffer bytes marked in pmask programmed at end of the cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem[i] <= eep_pkg::ERASED_BYTE;
			end
		end else if (prog_done) begin
			for (int j = 0; j < eep_pkg::PAGE_BYTES; j++) begin
				if (q.pmask[j]) begin
					mem[{q.ptr[ADDR_W-1:eep_pkg::PAGE_W], eep_pkg::PAGE_W'(j)}] <=
						q.pbuf[j];
				end
			end
		end
	end

	// Open-drain data line: only ever pulled low
	assign sda_o   = 1'b0;
	assign sda_oe  = q.drive_low;
	assign prdata  = q.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~reg_hit(paddr);
endmodule

/* File: logic/eep_pkg.sv */
// Shared constants and types for the serial EEPROM slave
package eep_pkg;
	localparam int          ADDR_W_DEF      = 11;
	localparam int          PAGE_BYTES      = 16;
	localparam int          PAGE_W          = 4;
	localparam int          SEL_BITS        = 3;
	localparam int          ARRAY_SEL_BASE  = 8;
	localparam logic [3:0]  DEV_CODE        = 4'hA;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT     = 4'h7;

	// Timing: internal_program_time is a longest time, so it rounds down
	localparam int          CLK_KHZ         = 20000;
	localparam int          PROG_TIME_MS    = 5;
	localparam int          PROG_CYCLES     = PROG_TIME_MS * CLK_KHZ;
	localparam int          SYNC_STAGES     = 2;

	// APB register map (byte addresses)
	localparam int          APB_AW          = 12;
	localparam logic [11:0] REG_CTRL        = 12'h000;
	localparam logic [11:0] REG_STATUS      = 12'h004;
	localparam logic [11:0] REG_ADDR        = 12'h008;
	localparam int          CTRL_EN_BIT     = 0;
	localparam logic        CTRL_EN_RST     = 1'b1;
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_WP_BIT     = 1;
	localparam int          STAT_ST_LSB     = 4;
	localparam int          STAT_ST_MSB     = 6;

	typedef enum logic [2:0] {
		EEP_IDLE  = 3'h0,
		EEP_DEV   = 3'h1,
		EEP_WORD  = 3'h2,
		EEP_DATA  = 3'h3,
		EEP_ACK   = 3'h4,
		EEP_TX    = 3'h5,
		EEP_TXACK = 3'h6
	} eep_state_t;
endpackage

/* File: logic/eep_sync.sv */
// Two-flop synchroniser for pin inputs, reset to the idle-high level
module eep_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= '1;
			sync_out <= '1;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

/* File: sim/eep_monitor.sv */
// Port-level checker for the serial EEPROM slave
module eep_monitor #(
	parameter int ADDR_W      = 11,
	parameter int PROG_CYCLES = 50
) (
	input wire logic                       clock,
	input wire logic                       resetn,
	input wire logic                       scl,
	input wire logic                       sda_i,
	input wire logic                       sda_o,
	input wire logic                       sda_oe,
	input wire logic                       write_protect,
	input wire logic                       device_select_pin_0,
	input wire logic                       device_select_pin_1,
	input wire logic                       device_select_pin_2,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [eep_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] hi_q;
	logic       mapped;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	assign mapped = paddr == eep_pkg::REG_CTRL || paddr == eep_pkg::REG_STATUS
		|| paddr == eep_pkg::REG_ADDR;
	// Clocks of SCL held high, saturating; long runs mean an idle bus
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) hi_q <= 4'h0;
		else hi_q <= !scl ? 4'h0 : (hi_q == 4'hF ? hi_q : hi_q + 4'h1);
	end
	chk_open_drain: assert property (sda_o == 1'b0)
		else $error("sda_o driven high");
	chk_ready_on: assert property (pready) else $error("pready low");
	chk_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
		else $error("sda_oe rose while scl high");
	chk_oe_hold_high: assert property ($rose(scl) |=> $stable(sda_oe) [*5])
		else $error("sda_oe changed while scl high");
	chk_idle_release: assert property (hi_q >= 4'hA |-> !sda_oe)
		else $error("sda held low on idle bus");
	chk_start_release: assert property (scl && $fell(sda_i) |=> !sda_oe [*8])
		else $error("sda driven during address bits");
	chk_bad_addr_err: assert property (psel && penable && !pwrite && !mapped
		|-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	chk_good_addr_ok: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped access refused");
endmodule

bind eep_core eep_monitor #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_mon (
	.clock(clock), .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .write_protect(write_protect),
	.device_select_pin_0(device_select_pin_0), .device_select_pin_1(device_select_pin_1),
	.device_select_pin_2(device_select_pin_2), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr)
);

/* File: sim/eep_master.sv */
// Behavioural two-wire bus master, the far-side partner
module eep_master (
	input  wire logic clock,
	input  wire logic sda,
	output      logic scl,
	output      logic sda_m
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Quarter of the 400 ns bit period
	task automatic step(input logic c, input logic d);
		repeat (2) @(posedge clock);
		scl <= c;
		sda_m <= d;
	endtask
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// Data changes only while SCL is low
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, b);
		step(1'b1, b);
		repeat (2) @(posedge clock);
		r = sda;
		step(1'b0, b);
	endtask
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rx(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!mack, r);
	endtask
endmodule

/* File: sim/tb_serial_eeprom_page_write_read.sv */
// Self-checking bench for the serial EEPROM slave
module tb_serial_eeprom_page_write_read;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, resetn, scl, sda, sda_m, sda_o, sda_oe, write_protect, dsel;
	logic psel, penable, pwrite, pready, pslverr, ack, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rb;
	int          errors, n_compared;
	assign sda = sda_m & !sda_oe;
	eep_master m (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
	eep_core #(.ADDR_W(11), .PROG_CYCLES(300)) dut (.clock(clock), .resetn(resetn),
		.scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.write_protect(write_protect), .device_select_pin_0(dsel),
		.device_select_pin_1(dsel), .device_select_pin_2(dsel), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic addr_byte(input logic [7:0] d, input logic exp);
		m.tx(d, ack);
		check(32'(ack), 32'(exp));
	endtask
	task automatic set_ptr(input logic [10:0] a);
		m.start();
		addr_byte({4'hA, a[10:8], 1'b0}, 1'b1);
		addr_byte(a[7:0], 1'b1);
	endtask
	task automatic rd_from(input logic [10:0] a);
		set_ptr(a);
		m.start();
		addr_byte({4'hA, a[10:8], 1'b1}, 1'b1);
	endtask
	task automatic poll(input logic exp);
		m.start();
		addr_byte(8'hA0, exp);
		m.stop();
	endtask
	task automatic t_apb();
		apb(1'b0, eep_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, 12'h00C, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, eep_pkg::REG_CTRL, 32'h0);
		poll(1'b0);
		apb(1'b1, eep_pkg::REG_CTRL, 32'h1);
	endtask
	task automatic t_erased();
		rd_from(11'h123);
		m.rx(1'b0, rb);
		check(32'(rb), 32'hFF);
		m.stop();
		apb(1'b0, eep_pkg::REG_ADDR, 32'h0);
		check(rd, 32'h124);
	endtask
	task automatic t_page();
		set_ptr(11'h01E);
		for (int i = 0; i < 18; i++) addr_byte(8'h40 + i[7:0], 1'b1);
		m.stop();
		repeat (4) @(posedge clock);
		apb(1'b0, eep_pkg::REG_STATUS, 32'h0);
		check(32'(rd[0]), 32'h1);
		poll(1'b0);
		repeat (320) @(posedge clock);
		poll(1'b1);
		apb(1'b0, eep_pkg::REG_ADDR, 32'h0);
		check(rd, 32'h10);
		rd_from(11'h010);
		for (int i = 0; i < 17; i++) begin
			m.rx(i < 16, rb);
			check(32'(rb), i == 16 ? 32'hFF : 32'h42 + i);
		end
		m.stop();
	endtask
	task automatic t_wrap();
		rd_from(11'h7FF);
		m.rx(1'b1, rb);
		m.rx(1'b0, rb);
		check(32'(rb), 32'hFF);
		m.stop();
		apb(1'b0, eep_pkg::REG_ADDR, 32'h0);
		check(rd, 32'h1);
	endtask
	task automatic t_wp();
		write_protect <= 1'b1;
		set_ptr(11'h050);
		addr_byte(8'h12, 1'b0);
		m.stop();
		apb(1'b0, eep_pkg::REG_STATUS, 32'h0);
		check(32'(rd[1:0]), 32'h2);
		poll(1'b1);
		write_protect <= 1'b0;
		set_ptr(11'h060);
		@(posedge clock);
		write_protect <= 1'b1;
		addr_byte(8'h34, 1'b1);
		m.stop();
		repeat (320) @(posedge clock);
		write_protect <= 1'b0;
		rd_from(11'h050);
		m.rx(1'b1, rb);
		check(32'(rb), 32'hFF);
		m.stop();
		rd_from(11'h060);
		m.rx(1'b0, rb);
		check(32'(rb), 32'h34);
		m.stop();
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		end_sim();
	end
	initial begin
		{resetn, psel, penable, pwrite, write_protect, dsel} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		t_apb();
		t_erased();
		t_page();
		t_wrap();
		t_wp();
		end_sim();
	end
endmodule
